// File: logic/lsz_consts.vh
/*
 register map, field positions and reset values of the sleep, auto-zero
 and interrupt-enable register group; included by the design files
*/
`ifndef LSZ_CONSTS_VH
`define LSZ_CONSTS_VH
`define LSZ_ADDR_STATUS 8'h93
`define LSZ_ADDR_SLEEP_CFG 8'hAB
`define LSZ_ADDR_AZ_CFG 8'hD6
`define LSZ_ADDR_INT_EN 8'hDD
`define LSZ_BIT_SAT 7
`define LSZ_BIT_THR 4
`define LSZ_BIT_SAI 4
`define LSZ_BIT_OFFSET_SEARCH_START 7
`define LSZ_AZ_RST 8'h7F
`define LSZ_AZ_NEVER 7'h00
`define LSZ_AZ_FIRST 7'h7F
`define LSZ_AZ_CNT_ONE 7'h01
`define LSZ_RST_BYTE 8'h00
`define LSZ_SLEEP_CFG_MASK 8'h10
`define LSZ_AZ_MASK 8'hFF
`define LSZ_INT_EN_MASK 8'h90
`define LSZ_STATUS_MASK 8'h90
`endif

// File: logic/lsz_az_sched.v
/*
 auto-zero scheduler: decides per light cycle whether auto-zero runs and
 where the offset search starts; assumes i_cycle_start pulses on i_clock
*/
`timescale 1ns/100ps
`default_nettype none
`include "lsz_consts.vh"
module lsz_az_sched (
    input wire i_clock,            // system clock
    input wire i_resetn,           // async reset, low
    input wire i_cycle_start,      // light cycle begins, pulse
    input wire i_first_cycle,      // first cycle after power-on
    input wire [6:0] i_interval,   // auto-zero interval field
    input wire i_start_mode,       // 1: start from previous offset
    output reg o_az_run,           // run auto-zero this cycle, pulse
    output reg o_az_from_prev      // search start selection
);
    reg [6:0] count_r;
    reg [6:0] count_nxt;
    reg run_nxt;

    always @* begin
        count_nxt = count_r;
        run_nxt = 1'b0;
        if (i_cycle_start) begin
            if (i_interval == `LSZ_AZ_NEVER) begin // [R7]
                count_nxt = `LSZ_AZ_NEVER;
            end else if (i_interval == `LSZ_AZ_FIRST) begin // [R7]
                run_nxt = i_first_cycle;
            end else if (i_first_cycle || count_r >= i_interval - `LSZ_AZ_CNT_ONE) begin // [R7]
                run_nxt = 1'b1;
                count_nxt = `LSZ_AZ_NEVER;
            end else begin
                count_nxt = count_r + `LSZ_AZ_CNT_ONE;
            end
        end
    end

    always @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            count_r <= `LSZ_AZ_NEVER;
            o_az_run <= 1'b0;
            o_az_from_prev <= 1'b0;
        end else begin
            count_r <= count_nxt;
            o_az_run <= run_nxt;
            o_az_from_prev <= i_start_mode; // [R6]
        end
    end
endmodule // lsz_az_sched
`default_nettype wire

// File: logic/lsz_sleep_irq.v
/*
 sleep-after-interrupt oscillator gating, status flags, interrupt enables
 and auto-zero settings; assumes a register port driven by the serial
 interface logic on i_clock and light-cycle events from the front end
*/
// How it works
// [R1] oscillator off without power-on; on with it unless asleep: pin low since a cycle end with sleep-after-irq set
// [R2] sleep-after-irq with pending interrupt at cycle end stops the oscillator
// [R3] clearing the pending flag at status 0x93, or its enable at 0xDD, wakes the device
// [R4] sleep-after-irq alters no register; it only gates the oscillator
// [R5] host writes zero to reserved bits 3:0 of the sleep config
// [R6] start-mode bit 7 picks search start: zero or previous offset
// [R7] interval 6:0: 0 never, 7Fh first only, n every nth; resets 7Fh
// [R8] enable bit 7 lets saturation flag drive the interrupt; resets 0
// [R9] enable bit 4 lets threshold flag drive the interrupt; resets 0
// [R10] writing 1 clears the matching status flag
// [R11] interrupt pin low while threshold flag and its enable are set
// [R12] reserved enable and auto-zero bits read zero and do nothing
`timescale 1ns/100ps
`default_nettype none
`include "lsz_consts.vh"
module lsz_sleep_irq (
    input wire i_clock,            // 100 MHz system clock
    input wire i_resetn,           // async reset, low
    input wire i_wr,               // register write strobe, pulse
    input wire i_rd,               // register read strobe, pulse
    input wire [7:0] i_addr,       // register address
    input wire [7:0] i_wdata,      // write data
    output reg [7:0] o_rdata,      // read data, valid cycle after i_rd
    input wire i_power_on_bit,     // power-on enable bit
    input wire i_cycle_start,      // light cycle begins, pulse
    input wire i_cycle_end,        // light cycle ends, pulse
    input wire i_threshold_event,  // threshold crossed, pulse
    input wire i_saturation_event, // analog saturation, pulse
    output wire o_int_oe_n,        // interrupt pin enable, low drives low
    output wire o_int_out,         // interrupt pin driven level
    output reg o_osc_on,           // oscillator run enable
    output wire o_az_run,          // run auto-zero this cycle, pulse
    output wire o_az_from_prev     // search starts at previous offset
);
    // interrupt sources, one generate entry each
    localparam NUM_SRC = 2;
    localparam SRC_THR = 0;
    localparam SRC_SAT = 1;

    reg sai_r;
    reg sai_nxt;
    reg [7:0] az_cfg_r;
    reg [7:0] az_cfg_nxt;
    reg sat_en_r;
    reg sat_en_nxt;
    reg thr_en_r;
    reg thr_en_nxt;
    reg sleep_r;
    reg sleep_nxt;
    reg first_r;
    reg first_nxt;
    reg osc_nxt;
    reg [7:0] rdata_nxt;
    wire [NUM_SRC-1:0] src_event;
    wire [NUM_SRC-1:0] src_clear;
    wire [NUM_SRC-1:0] src_enable;
    wire [NUM_SRC-1:0] src_flag;
    wire wr_status;
    wire wr_sleep_cfg;
    wire wr_az_cfg;
    wire wr_int_en;
    wire cycle_start_ok;
    wire irq_n;
    genvar g;

    // one write strobe per register; unmapped writes fall through
    assign wr_status = i_wr && (i_addr == `LSZ_ADDR_STATUS);
    assign wr_sleep_cfg = i_wr && (i_addr == `LSZ_ADDR_SLEEP_CFG);
    assign wr_az_cfg = i_wr && (i_addr == `LSZ_ADDR_AZ_CFG);
    assign wr_int_en = i_wr && (i_addr == `LSZ_ADDR_INT_EN);

    // reserved bits are simply not stored, so they read zero and act on nothing
    always @* begin
        sai_nxt = sai_r;
        az_cfg_nxt = az_cfg_r;
        sat_en_nxt = sat_en_r;
        thr_en_nxt = thr_en_r;
        if (wr_sleep_cfg) begin
            sai_nxt = i_wdata[`LSZ_BIT_SAI];
        end
        if (wr_az_cfg) begin
            az_cfg_nxt = i_wdata & `LSZ_AZ_MASK; // [R6] [R7]
        end
        if (wr_int_en) begin
            sat_en_nxt = i_wdata[`LSZ_BIT_SAT]; // [R8]
            thr_en_nxt = i_wdata[`LSZ_BIT_THR]; // [R9] [R12]
        end
    end

    always @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            sai_r <= 1'b0;
            az_cfg_r <= `LSZ_AZ_RST; // [R7]
            sat_en_r <= 1'b0; // [R8]
            thr_en_r <= 1'b0; // [R9]
        end else begin
            sai_r <= sai_nxt;
            az_cfg_r <= az_cfg_nxt;
            sat_en_r <= sat_en_nxt;
            thr_en_r <= thr_en_nxt;
        end
    end

    assign src_event[SRC_THR] = i_threshold_event;
    assign src_event[SRC_SAT] = i_saturation_event;
    assign src_clear[SRC_THR] = wr_status && i_wdata[`LSZ_BIT_THR]; // [R10]
    assign src_clear[SRC_SAT] = wr_status && i_wdata[`LSZ_BIT_SAT]; // [R10]
    assign src_enable[SRC_THR] = thr_en_r; // [R9]
    assign src_enable[SRC_SAT] = sat_en_r; // [R8]

    // set wins over a clear in the same cycle, so no event is lost
    generate
        for (g = 0; g < NUM_SRC; g = g + 1) begin : g_src
            reg flag_r;
            reg flag_nxt;
            always @* begin
                flag_nxt = flag_r;
                if (src_event[g]) begin
                    flag_nxt = 1'b1;
                end else if (src_clear[g]) begin
                    flag_nxt = 1'b0; // [R10]
                end
            end
            always @(posedge i_clock or negedge i_resetn) begin
                if (!i_resetn) begin
                    flag_r <= 1'b0;
                end else begin
                    flag_r <= flag_nxt;
                end
            end
            assign src_flag[g] = flag_r;
        end
    endgenerate

    // the pin is the signal the sleep logic watches
    assign irq_n = ~|(src_flag & src_enable); // [R11] [R8] [R9]
    assign o_int_out = 1'b0;
    assign o_int_oe_n = irq_n; // [R11]

    // a start seen with the oscillator stopped is no light cycle
    assign cycle_start_ok = i_cycle_start && o_osc_on;

    // sleep only gates the oscillator; no register is touched here
    always @* begin
        sleep_nxt = sleep_r;
        first_nxt = first_r;
        if (!i_power_on_bit || irq_n) begin
            sleep_nxt = 1'b0; // [R3] [R4]
        end else if (sai_r && i_cycle_end) begin
            sleep_nxt = 1'b1; // [R2]
        end
        if (!i_power_on_bit) begin
            first_nxt = 1'b1;
        end else if (cycle_start_ok) begin
            first_nxt = 1'b0;
        end
        // sleep is only entered at cycle end, so a running cycle finishes
        osc_nxt = i_power_on_bit && !sleep_r; // [R1]
    end

    always @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            sleep_r <= 1'b0;
            first_r <= 1'b1;
            o_osc_on <= 1'b0;
        end else begin
            sleep_r <= sleep_nxt;
            first_r <= first_nxt;
            o_osc_on <= osc_nxt;
        end
    end

    // reserved positions keep the zero of the default byte
    always @* begin
        rdata_nxt = `LSZ_RST_BYTE;
        case (i_addr)
            `LSZ_ADDR_STATUS: begin
                rdata_nxt[`LSZ_BIT_SAT] = src_flag[SRC_SAT];
                rdata_nxt[`LSZ_BIT_THR] = src_flag[SRC_THR];
            end
            `LSZ_ADDR_SLEEP_CFG: begin
                rdata_nxt[`LSZ_BIT_SAI] = sai_r;
            end
            `LSZ_ADDR_AZ_CFG: begin
                rdata_nxt = az_cfg_r & `LSZ_AZ_MASK;
            end
            `LSZ_ADDR_INT_EN: begin
                rdata_nxt[`LSZ_BIT_SAT] = sat_en_r; // [R12]
                rdata_nxt[`LSZ_BIT_THR] = thr_en_r; // [R12]
            end
            default: begin
                rdata_nxt = `LSZ_RST_BYTE;
            end
        endcase
    end

    // status reads have no side effect; data holds until the next read
    always @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdata <= `LSZ_RST_BYTE;
        end else if (i_rd) begin
            o_rdata <= rdata_nxt;
        end
    end

    // the scheduler sees only accepted starts, so its count skips sleep
    lsz_az_sched u_az (
        .i_clock(i_clock),
        .i_resetn(i_resetn),
        .i_cycle_start(cycle_start_ok),
        .i_first_cycle(first_r),
        .i_interval(az_cfg_r[6:0]),
        .i_start_mode(az_cfg_r[`LSZ_BIT_OFFSET_SEARCH_START]),
        .o_az_run(o_az_run),
        .o_az_from_prev(o_az_from_prev)
    );
endmodule // lsz_sleep_irq
`default_nettype wire

// File: verification/lsz_sleep_irq_props.sv
/* checker of the sleep, pin and read-port relations of lsz_sleep_irq
   sees only the ports of lsz_sleep_irq, bound below */
`timescale 1ns/100ps
`default_nettype none
module lsz_chk (
    input wire logic i_clock, // clock
    input wire logic i_resetn, // reset, low
    input wire logic i_wr, // write strobe
    input wire logic i_rd, // read strobe
    input wire logic [7:0] i_addr, // address
    input wire logic [7:0] i_wdata, // write data
    input wire logic [7:0] o_rdata, // read data
    input wire logic i_power_on_bit, // power-on
    input wire logic i_cycle_end, // cycle end
    input wire logic i_threshold_event, // threshold
    input wire logic i_saturation_event, // saturation
    input wire logic o_int_oe_n, // pin enable
    input wire logic o_osc_on // oscillator
);
    logic sai_r;
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_resetn);
    // shadow of the sleep bit, the pin alone cannot say if sleep applies
    always @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) sai_r <= 1'b0;
        else if (i_wr && i_addr == 8'hAB) sai_r <= i_wdata[4];
    end
    sequence s_irq_end;
        sai_r && i_power_on_bit && !o_int_oe_n && i_cycle_end;
    endsequence
    sequence s_awake;
        (i_power_on_bit && o_int_oe_n) [*4];
    endsequence
    a_osc_no_power: assert property (!i_power_on_bit [*2] |-> !o_osc_on)
        else $error("osc runs without power");
    a_osc_run_awake: assert property (s_awake |-> o_osc_on)
        else $error("osc stopped while pin idle");
    a_sleep_enter: assert property (s_irq_end |-> ##2 !o_osc_on)
        else $error("no sleep after irq");
    a_flag_clear_pin: assert property (i_wr && i_addr == 8'h93 && i_wdata == 8'h90
        && !i_threshold_event && !i_saturation_event |=> o_int_oe_n) else $error("pin kept");
    a_enables_off: assert property (i_wr && i_addr == 8'hDD && !i_wdata[7] && !i_wdata[4]
        |=> o_int_oe_n) else $error("pin without enable");
    a_rsv_read_zero: assert property (i_rd && i_addr == 8'hDD |=> (o_rdata & 8'h6F) == 0)
        else $error("reserved bits set");
    a_unmapped_zero: assert property (i_rd && i_addr == 8'h00 |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (!i_rd |=> $stable(o_rdata))
        else $error("read data moved");
endmodule // lsz_chk
bind lsz_sleep_irq lsz_chk u_chk (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .o_rdata(o_rdata),
    .i_power_on_bit(i_power_on_bit),
    .i_cycle_end(i_cycle_end),
    .i_threshold_event(i_threshold_event),
    .i_saturation_event(i_saturation_event),
    .o_int_oe_n(o_int_oe_n),
    .o_osc_on(o_osc_on)
);
`default_nettype wire

// File: verification/lsz_host_model.sv
/* host model: single-byte writes and reads on the register port
   assumes its tasks are called from one process */
`timescale 1ns/100ps
`default_nettype none
module lsz_host_model (
    input wire logic i_clock, // clock
    input wire logic [7:0] i_rdata, // read data
    output var logic o_wr = 1'b0, // write
    output var logic o_rd = 1'b0, // read
    output var logic [7:0] o_addr = 8'h00, // address
    output var logic [7:0] o_wdata = 8'h00 // data
);
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clock);
        {o_wr, o_addr} <= {1'b1, a};
        o_wdata <= (a == 8'hAB) ? (d & 8'hF0) : d;
        @(posedge i_clock);
        {o_wr, o_addr, o_wdata} <= {1'b0, ~a, ~d}; // released lines toggle
    endtask
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clock);
        {o_rd, o_addr} <= {1'b1, a};
        @(posedge i_clock);
        {o_rd, o_addr} <= {1'b0, ~a};
        @(posedge i_clock);
        #1 d = i_rdata;
    endtask
endmodule // lsz_host_model
`default_nettype wire

// File: verification/tb.sv
/* self-checking bench of lsz_sleep_irq
   assumes the host model on the register port, events driven here */
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin num_errors++; \
    $display("BAD %s exp %h got %h", n, e, a); end end
module tb;
    logic clk, rst_n = 1'b0, power_on_bit = 1'b0, wr, rd, oe_n, iout, osc, az, azp;
    logic [3:0] evt = 4'h0;
    logic [7:0] addr, wdata, rdata, rv;
    int num_errors = 0, compares = 0, cyc = 0, runs = 0;
    logic [23:0] rows [4] = '{24'hD685_85, 24'hDDFF_90, 24'h00FF_00, 24'hDD00_00};
    logic [15:0] azt [4] = '{16'h7F_01, 16'h00_00, 16'h01_04, 16'h03_02};
    lsz_host_model host (.i_clock(clk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd),
        .o_addr(addr), .o_wdata(wdata));
    lsz_sleep_irq dut (.i_clock(clk), .i_resetn(rst_n), .i_wr(wr), .i_rd(rd), .i_addr(addr),
        .i_wdata(wdata), .o_rdata(rdata), .i_power_on_bit(power_on_bit), .i_cycle_start(evt[3]),
        .i_cycle_end(evt[2]), .i_threshold_event(evt[0]), .i_saturation_event(evt[1]),
        .o_int_oe_n(oe_n), .o_int_out(iout), .o_osc_on(osc), .o_az_run(az), .o_az_from_prev(azp));
    initial begin clk = 1'b0; forever #5 clk = ~clk; end
    always @(posedge clk) begin
        cyc++;
        if (az) runs++;
        if (cyc == 5000) begin num_errors++; summarize; end
    end
    task summarize;
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task tick(input int n); repeat (n) @(posedge clk); #1; endtask
    task pulse(input int k);
        @(posedge clk) evt <= 4'h1 << k;
        @(posedge clk) evt <= 4'h0;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        host.rd(8'hD6, rv);
        `CHK("az reset", 8'h7F, rv)
        host.rd(8'hDD, rv);
        `CHK("en reset", 8'h00, rv)
        foreach (rows[i]) begin
            host.wr(rows[i][23:16], rows[i][15:8]);
            host.rd(rows[i][23:16], rv);
            `CHK("readback", rows[i][7:0], rv)
        end
        `CHK("az start", 1'b1, azp)
        $display("regs done");
        for (int k = 0; k < 2; k++) begin
            host.wr(8'hDD, k ? 8'h80 : 8'h10);
            pulse(k);
            tick(1);
            `CHK("pin on", 1'b0, oe_n)
            `CHK("pin level", 1'b0, iout)
            host.wr(8'h93, 8'h90);
            tick(1);
            `CHK("pin off", 1'b1, oe_n)
        end
        $display("irq done");
        @(posedge clk) power_on_bit <= 1'b1;
        host.wr(8'hAB, 8'h10);
        host.wr(8'hDD, 8'h10);
        tick(1);
        `CHK("run", 1'b1, osc)
        pulse(0);
        pulse(2);
        tick(3);
        `CHK("sleep", 1'b0, osc)
        host.rd(8'hDD, rv);
        `CHK("regs kept", 8'h10, rv)
        host.wr(8'h93, 8'h90);
        tick(4);
        `CHK("wake", 1'b1, osc)
        @(posedge clk) power_on_bit <= 1'b0;
        tick(3);
        `CHK("off", 1'b0, osc)
        $display("sleep done");
        foreach (azt[i]) begin
            host.wr(8'hD6, azt[i][15:8]);
            @(posedge clk) power_on_bit <= 1'b1;
            tick(3);
            runs = 0;
            repeat (4) pulse(3);
            tick(2);
            `CHK("az runs", azt[i][7:0], runs[7:0])
            @(posedge clk) power_on_bit <= 1'b0;
        end
        `CHK("az zero start", 1'b0, azp)
        $display("az done");
        fork
            host.wr(8'h93, 8'h90);
            pulse(0);
        join
        tick(1);
        `CHK("set wins", 1'b0, oe_n)
        $display("flag race done");
        @(posedge clk) power_on_bit <= 1'b1;
        tick(3);
        @(posedge clk) rst_n <= 1'b0;
        tick(1);
        `CHK("rst pin", 1'b1, oe_n)
        `CHK("rst osc", 1'b0, osc)
        @(posedge clk) rst_n <= 1'b1;
        host.rd(8'hD6, rv);
        `CHK("rst az", 8'h7F, rv)
        host.rd(8'hDD, rv);
        `CHK("rst en", 8'h00, rv)
        tick(1);
        `CHK("rst run", 1'b1, osc)
        $display("reset done");
        summarize;
    end
endmodule // tb
`default_nettype wire
